// ==== src/dtm_pkg.sv ====
package dtm_pkg;
   // Register index on the plain register port
   localparam int unsigned AW = 4;
   localparam logic [AW-1:0] OFS_PTE   = 4'h0;
   localparam logic [AW-1:0] OFS_HOLD  = 4'h1;
   localparam logic [AW-1:0] OFS_SYN   = 4'h2;
   localparam logic [AW-1:0] OFS_FVA   = 4'h3;
   localparam logic [AW-1:0] OFS_ZAP   = 4'h4;
   localparam logic [AW-1:0] OFS_NGINV = 4'h5;
   localparam logic [AW-1:0] OFS_SINV  = 4'h6;
   localparam logic [AW-1:0] OFS_ICFL  = 4'h7;
   localparam logic [AW-1:0] OFS_ICNG  = 4'h8;
   localparam logic [AW-1:0] OFS_PSEL  = 4'h9;
   localparam logic [AW-1:0] OFS_PTAG  = 4'ha;
   // Array geometry
   localparam int SM_N  = 32;
   localparam int LG_N  = 4;
   localparam int SM_IW = 5;
   localparam int LG_IW = 2;
   localparam int VA_W  = 43;
   localparam int SM_TW = 30;   // VA[42:13]
   localparam int LG_TW = 21;   // VA[42:22]
   localparam int SM_TL = 13;
   localparam int PFN_W = 21;   // PA[33:13]
   localparam int LG_CUT = 9;   // PAGE_FRAME_NUMBER bits unused by large pages
   // Page size select: this value picks the large array
   localparam logic [1:0] LG_SEL = 2'h3;
   localparam logic [1:0] PSEL_RST = 2'h0;
   // Memory-format entry layout
   localparam int PTE_FOR = 1;
   localparam int PTE_FOW = 2;
   localparam int PTE_GBL = 4;
   localparam int PTE_PRM = 8;
   localparam int PTE_PFN = 32;
   // Holding register layout
   localparam int HLD_FOR = 3;
   localparam int HLD_FOW = 4;
   localparam int HLD_WE  = 5;
   localparam int HLD_RE  = 9;
   localparam int HLD_PFN = 13;
   localparam int HLD_GBL = 34;
   // Syndrome layout
   localparam int SYN_WR  = 0;
   localparam int SYN_ACV = 1;
   localparam int SYN_FOR = 2;
   localparam int SYN_FOW = 3;
   localparam int SYN_RA  = 4;
   localparam int SYN_OPC = 9;

   typedef struct packed {
      logic             gbl;
      logic [PFN_W-1:0] page_frame_number;
      logic [7:0]       perm;  // {wr uskE..., rd} as in memory format
      logic             fault_on_store_bit;
      logic             frd;
   } dtm_pte_t;

   typedef struct packed {
      logic            st;
      logic            access_violation_flag;
      logic            frd;
      logic            fault_on_store_bit;
      logic [4:0]      ra;
      logic [5:0]      opc;
      logic [VA_W-1:0] va;
   } dtm_flt_t;
endpackage

// ==== src/dtm_core.sv ====
`timescale 1ns/100ps
// Behaviour
// [RULE_01] 32 small, 4 large entries, NOT_LAST_USED_POINTER placement
// [RULE_02] Memory-format write, no valid bit stored
// [RULE_03] Tag loaded from pending tag on write
// [RULE_04] Entry read goes via holding register
// [RULE_05] Each entry access advances selected pointer
// [RULE_06] Holding register read-only, unused bits zero
// [RULE_07] Fault syndrome captured while unlocked
// [RULE_08] Store flag and access-violation flag
// [RULE_09] Fault-on-read and fault-on-store flags
// [RULE_10] Source register and opcode recorded, read-only
// [RULE_11] Fault or miss latches virtual address
// [RULE_12] Lock until fault address is read
// [RULE_13] Status changes only unlocked, on error/miss
// [RULE_14] Reset leaves capture unlocked
// [RULE_15] Software unlocks before leaving higher handlers
// [RULE_16] Invalidate-all clears entries, resets pointers
// [RULE_17] Non-global invalidate keeps global entries
// [RULE_18] Single invalidate removes matching entries
// [RULE_19] Icache flush command flushes all
// [RULE_20] Non-global icache flush command
// [RULE_21] Select 11 picks large array
// [RULE_22] Invalidates finish before next lookup
module dtm_core (
   input  wire logic                      sys_clk_i,
   input  wire logic                      arst_n_i,
   input  wire logic [dtm_pkg::AW-1:0]    reg_addr_i,
   input  wire logic [63:0]               reg_wdata_i,
   input  wire logic                      reg_we_i,
   input  wire logic                      reg_re_i,
   output logic      [63:0]               reg_rdata_o,
   input  wire logic                      lk_req_i,
   input  wire logic [dtm_pkg::VA_W-1:0]  lk_va_i,
   output logic                           lk_done_o,
   output logic                           lk_hit_o,
   output dtm_pkg::dtm_pte_t              lk_pte_o,
   input  wire logic                      flt_err_i,
   input  wire logic                      flt_miss_i,
   input  wire dtm_pkg::dtm_flt_t         flt_info_i,
   output logic                           flt_locked_o,
   output logic                           ic_flush_all_o,
   output logic                           ic_flush_ng_o
);

   localparam int SM_N = dtm_pkg::SM_N;
   localparam int LG_N = dtm_pkg::LG_N;
   localparam int SW   = dtm_pkg::SM_TW;
   localparam int LW   = dtm_pkg::LG_TW;
   localparam int VH   = dtm_pkg::VA_W - 1;

   // Decode of register strokes
   logic wr_pte;
   logic rd_pte;
   logic rd_fva;
   logic wr_zap;
   logic wr_ng;
   logic wr_sinv;
   logic cmd_inv;
   assign wr_pte  = reg_we_i && (reg_addr_i == dtm_pkg::OFS_PTE);
   assign rd_pte  = reg_re_i && (reg_addr_i == dtm_pkg::OFS_PTE);
   assign rd_fva  = reg_re_i && (reg_addr_i == dtm_pkg::OFS_FVA);
   assign wr_zap  = reg_we_i && (reg_addr_i == dtm_pkg::OFS_ZAP);
   assign wr_ng   = reg_we_i && (reg_addr_i == dtm_pkg::OFS_NGINV);
   assign wr_sinv = reg_we_i && (reg_addr_i == dtm_pkg::OFS_SINV);
   assign cmd_inv = wr_zap || wr_ng || wr_sinv;

   // Storage
   dtm_pkg::dtm_pte_t        sm_pte_q [SM_N];
   dtm_pkg::dtm_pte_t        lg_pte_q [LG_N];
   logic [SW-1:0]            sm_tag_q [SM_N];
   logic [LW-1:0]            lg_tag_q [LG_N];
   logic [SM_N-1:0]          sm_vld_q;
   logic [LG_N-1:0]          lg_vld_q;
   logic [dtm_pkg::SM_IW-1:0] sm_ptr_q;
   logic [dtm_pkg::LG_IW-1:0] lg_ptr_q;
   logic [1:0]               psel_q;
   logic [SW-1:0]            ptag_q;
   logic [63:0]              hold_q;
   logic [14:0]              syn_q;
   logic [VH:0]              fva_q;
   logic                     lock_q;
   logic                     use_lg;

   assign use_lg = (psel_q == dtm_pkg::LG_SEL); // RULE_21

   // Memory-format write data to stored fields; other bits ignored
   function automatic dtm_pkg::dtm_pte_t from_mem(input logic [63:0] d,
                                                   input logic lg);
      dtm_pkg::dtm_pte_t p;
      p.gbl  = d[dtm_pkg::PTE_GBL];
      p.page_frame_number  = d[dtm_pkg::PTE_PFN +: dtm_pkg::PFN_W];
      p.perm = d[dtm_pkg::PTE_PRM +: 8];
      p.fault_on_store_bit  = d[dtm_pkg::PTE_FOW];
      p.frd  = d[dtm_pkg::PTE_FOR];
      if (lg) begin
         p.page_frame_number[dtm_pkg::LG_CUT-1:0] = '0;
      end
      return p;
   endfunction

   // Stored entry to holding register layout; rest reads zero
   function automatic logic [63:0] to_hold(input dtm_pkg::dtm_pte_t p);
      logic [63:0] h;
      h = '0;
      h[dtm_pkg::HLD_GBL]              = p.gbl;
      h[dtm_pkg::HLD_PFN +: dtm_pkg::PFN_W] = p.page_frame_number;
      h[dtm_pkg::HLD_RE +: 4]          = p.perm[3:0];
      h[dtm_pkg::HLD_WE +: 4]          = p.perm[7:4];
      h[dtm_pkg::HLD_FOW]              = p.fault_on_store_bit;
      h[dtm_pkg::HLD_FOR]              = p.frd;
      return h;
   endfunction

   // Per-entry match and clear terms
   logic [SM_N-1:0] sm_lk_m;
   logic [SM_N-1:0] sm_clr;
   logic [SM_N-1:0] sm_set;
   logic [LG_N-1:0] lg_lk_m;
   logic [LG_N-1:0] lg_clr;
   logic [LG_N-1:0] lg_set;

   genvar gi;
   generate
      for (gi = 0; gi < SM_N; gi++) begin : g_sm
         assign sm_lk_m[gi] = sm_vld_q[gi] && (sm_tag_q[gi] == lk_va_i[VH:dtm_pkg::SM_TL]);
         assign sm_clr[gi]  = wr_zap                                  // RULE_16
                            || (wr_ng && !sm_pte_q[gi].gbl)           // RULE_17
                            || (wr_sinv && (sm_tag_q[gi] == reg_wdata_i[VH:dtm_pkg::SM_TL])); // RULE_18
         assign sm_set[gi]  = wr_pte && !use_lg && (sm_ptr_q == gi);
      end
      for (gi = 0; gi < LG_N; gi++) begin : g_lg
         assign lg_lk_m[gi] = lg_vld_q[gi] && (lg_tag_q[gi] == lk_va_i[VH -: LW]);
         assign lg_clr[gi]  = wr_zap                                  // RULE_16
                            || (wr_ng && !lg_pte_q[gi].gbl)           // RULE_17
                            || (wr_sinv && (lg_tag_q[gi] == reg_wdata_i[VH -: LW])); // RULE_18
         assign lg_set[gi]  = wr_pte && use_lg && (lg_ptr_q == gi);
      end
   endgenerate

   // Valid bits live beside the arrays, never in the entry data
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sm_vld_q <= '0;
         lg_vld_q <= '0;
      end else begin
         sm_vld_q <= (sm_vld_q & ~sm_clr) | sm_set; // RULE_02
         lg_vld_q <= (lg_vld_q & ~lg_clr) | lg_set;
      end
   end

   // Entry write: data and tag land together so they never disagree
   always_ff @(posedge sys_clk_i) begin
      if (wr_pte && !use_lg) begin
         sm_pte_q[sm_ptr_q] <= from_mem(reg_wdata_i, 1'b0); // RULE_01 RULE_02
         sm_tag_q[sm_ptr_q] <= ptag_q;                      // RULE_03
      end
      if (wr_pte && use_lg) begin
         lg_pte_q[lg_ptr_q] <= from_mem(reg_wdata_i, 1'b1); // RULE_01 RULE_02
         lg_tag_q[lg_ptr_q] <= ptag_q[SW-1 -: LW];          // RULE_03
      end
   end

   // Lookup hit search; one hit expected, lowest index wins otherwise
   logic                      sm_hit;
   logic                      lg_hit;
   logic [dtm_pkg::SM_IW-1:0] sm_hidx;
   logic [dtm_pkg::LG_IW-1:0] lg_hidx;
   always_comb begin
      sm_hit  = 1'b0;
      sm_hidx = '0;
      for (int i = SM_N - 1; i >= 0; i--) begin
         if (sm_lk_m[i]) begin
            sm_hit  = 1'b1;
            sm_hidx = i[dtm_pkg::SM_IW-1:0];
         end
      end
      lg_hit  = 1'b0;
      lg_hidx = '0;
      for (int i = LG_N - 1; i >= 0; i--) begin
         if (lg_lk_m[i]) begin
            lg_hit  = 1'b1;
            lg_hidx = i[dtm_pkg::LG_IW-1:0];
         end
      end
   end

   // Lookup answer one cycle later; an invalidate in the same
   // cycle forces a miss since the arrays are still old
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lk_done_o <= 1'b0;
         lk_hit_o  <= 1'b0;
         lk_pte_o  <= '0;
      end else begin
         lk_done_o <= lk_req_i;
         lk_hit_o  <= lk_req_i && !cmd_inv && (sm_hit || lg_hit); // RULE_22
         lk_pte_o  <= sm_hit ? sm_pte_q[sm_hidx] : lg_pte_q[lg_hidx];
      end
   end

   // Not-last-used pointers: step on each entry access, and step
   // off an entry that a lookup just used
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sm_ptr_q <= '0;
         lg_ptr_q <= '0;
      end else if (wr_zap) begin
         sm_ptr_q <= '0; // RULE_16
         lg_ptr_q <= '0;
      end else if (wr_pte || rd_pte) begin
         if (use_lg) begin
            lg_ptr_q <= lg_ptr_q + 1'b1; // RULE_05
         end else begin
            sm_ptr_q <= sm_ptr_q + 1'b1; // RULE_05
         end
      end else if (lk_req_i && !cmd_inv) begin
         if (sm_hit && sm_hidx == sm_ptr_q) begin
            sm_ptr_q <= sm_ptr_q + 1'b1; // RULE_01
         end
         if (!sm_hit && lg_hit && lg_hidx == lg_ptr_q) begin
            lg_ptr_q <= lg_ptr_q + 1'b1;
         end
      end
   end

   // Software control: page size select and pending tag
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         psel_q <= dtm_pkg::PSEL_RST;
         ptag_q <= '0;
      end else begin
         if (reg_we_i && reg_addr_i == dtm_pkg::OFS_PSEL) begin
            psel_q <= reg_wdata_i[1:0];
         end
         if (reg_we_i && reg_addr_i == dtm_pkg::OFS_PTAG) begin
            ptag_q <= reg_wdata_i[VH:dtm_pkg::SM_TL];
         end
      end
   end

   // First read step copies the pointed entry into the hold
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hold_q <= '0;
      end else if (rd_pte) begin
         hold_q <= use_lg ? to_hold(lg_pte_q[lg_ptr_q])  // RULE_04 RULE_06
                          : to_hold(sm_pte_q[sm_ptr_q]);
      end
   end

   // Fault capture; a read of the fault address reopens it. A new
   // event while locked is dropped, which is why the handler must
   // read the address before it returns
   logic cap;
   assign cap = (flt_err_i || flt_miss_i) && !lock_q; // RULE_07 RULE_13
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lock_q <= 1'b0; // RULE_14
         syn_q  <= '0;
         fva_q  <= '0;
      end else if (cap) begin
         lock_q <= 1'b1;                   // RULE_12
         fva_q  <= flt_info_i.va;          // RULE_11
         syn_q[dtm_pkg::SYN_WR]  <= flt_info_i.st;                    // RULE_08
         syn_q[dtm_pkg::SYN_ACV] <= flt_err_i && flt_info_i.access_violation_flag;      // RULE_08
         syn_q[dtm_pkg::SYN_FOR] <= flt_err_i && !flt_info_i.st && flt_info_i.frd; // RULE_09
         syn_q[dtm_pkg::SYN_FOW] <= flt_err_i && flt_info_i.st && flt_info_i.fault_on_store_bit;  // RULE_09
         syn_q[dtm_pkg::SYN_RA +: 5]  <= flt_info_i.ra;               // RULE_10
         syn_q[dtm_pkg::SYN_OPC +: 6] <= flt_info_i.opc;              // RULE_10
      end else if (rd_fva) begin
         lock_q <= 1'b0; // RULE_12 RULE_15
      end
   end

   // Read data stands in the cycle after the strobe only
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= '0;
      end else if (!reg_re_i) begin
         reg_rdata_o <= '0;
      end else begin
         unique case (reg_addr_i)
            dtm_pkg::OFS_HOLD: reg_rdata_o <= hold_q;          // RULE_04 RULE_06
            dtm_pkg::OFS_SYN:  reg_rdata_o <= 64'(syn_q);      // RULE_10
            dtm_pkg::OFS_FVA:  reg_rdata_o <= 64'(fva_q);      // RULE_11
            dtm_pkg::OFS_PSEL: reg_rdata_o <= 64'(psel_q);
            dtm_pkg::OFS_PTAG: reg_rdata_o <= 64'({ptag_q, 13'h0});
            default:           reg_rdata_o <= '0;
         endcase
      end
   end

   // Icache flush requests, one cycle each, plus lock status
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ic_flush_all_o <= 1'b0;
         ic_flush_ng_o  <= 1'b0;
         flt_locked_o   <= 1'b0;
      end else begin
         ic_flush_all_o <= reg_we_i && reg_addr_i == dtm_pkg::OFS_ICFL; // RULE_19
         ic_flush_ng_o  <= reg_we_i && reg_addr_i == dtm_pkg::OFS_ICNG; // RULE_20
         flt_locked_o   <= (lock_q && !rd_fva) || cap; // RULE_12 tracks lock_q
      end
   end

endmodule

// ==== dv/dtm_core_props.sv ====
`timescale 1ns/100ps
// Port-level checks on read-as-zero fields, capture lock and command pulses
module dtm_core_props (
   input wire logic                   sys_clk_i,
   input wire logic                   arst_n_i,
   input wire logic [dtm_pkg::AW-1:0] reg_addr_i,
   input wire logic                   reg_we_i,
   input wire logic                   reg_re_i,
   input wire logic [63:0]            reg_rdata_o,
   input wire logic                   lk_req_i,
   input wire logic                   lk_done_o,
   input wire logic                   lk_hit_o,
   input wire logic                   flt_err_i,
   input wire logic                   flt_miss_i,
   input wire logic                   flt_locked_o,
   input wire logic                   ic_flush_all_o,
   input wire logic                   ic_flush_ng_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   // Decoded strobes; kept as nets so the properties stay short
   wire unl  = reg_re_i && reg_addr_i == dtm_pkg::OFS_FVA;
   wire icfl = reg_we_i && reg_addr_i == dtm_pkg::OFS_ICFL;
   wire icng = reg_we_i && reg_addr_i == dtm_pkg::OFS_ICNG;
   wire inv  = reg_we_i && reg_addr_i inside {dtm_pkg::OFS_ZAP, dtm_pkg::OFS_NGINV, dtm_pkg::OFS_SINV};
   // Capture only starts from the unlocked state
   sequence s_capture;
      !flt_locked_o ##0 (flt_err_i || flt_miss_i);
   endsequence
   sequence s_unlock;
      flt_locked_o ##0 unl;
   endsequence
   a_hold_raz: assert property (reg_re_i && reg_addr_i == dtm_pkg::OFS_HOLD |=>
      reg_rdata_o[63:35] == 29'h0 && reg_rdata_o[2:0] == 3'h0) else $error("hold unused bits not zero");
   a_syn_raz: assert property (reg_re_i && reg_addr_i == dtm_pkg::OFS_SYN |=>
      reg_rdata_o[63:15] == 49'h0) else $error("syndrome upper bits not zero");
   a_lock_capture: assert property (s_capture |=> flt_locked_o) else $error("fault did not lock");
   a_lock_holds: assert property (flt_locked_o && !unl |=> flt_locked_o) else $error("lock lost");
   a_lock_release: assert property (s_unlock |=> !flt_locked_o) else $error("address read kept lock");
   a_no_spur_lock: assert property (!flt_locked_o && !flt_err_i && !flt_miss_i |=>
      !flt_locked_o) else $error("lock without event");
   a_inv_miss: assert property (lk_req_i && inv |=> lk_done_o && !lk_hit_o) else $error("hit during invalidate");
   a_icfl_pulse: assert property (ic_flush_all_o == $past(icfl)) else $error("flush pulse wrong");
   a_icng_pulse: assert property (ic_flush_ng_o == $past(icng)) else $error("ng flush pulse wrong");
endmodule

// ==== dv/dtm_lsu_model.sv ====
`timescale 1ns/100ps
// Load/store pipeline stand-in: issues lookups and fault reports
module dtm_lsu_model (
   input  wire logic              sys_clk_i,
   input  wire logic              done_i,
   input  wire logic              hit_i,
   input  wire dtm_pkg::dtm_pte_t pte_i,
   output logic                   req_o,
   output logic [42:0]            va_o,
   output logic                   err_o,
   output logic                   miss_o,
   output dtm_pkg::dtm_flt_t      info_o
);
   // Idle qualifiers drop to zero and the address and info buses show the inverse of the last value, so stale data cannot pass
   initial begin
      req_o = 1'b0;
      va_o = 43'h0;
      err_o = 1'b0;
      miss_o = 1'b0;
      info_o = '0;
   end
   // Answer is registered, sampled after the edge that takes the request
   task automatic lookup(input logic [42:0] va, output logic hit, output dtm_pkg::dtm_pte_t pte);
      @(posedge sys_clk_i);
      req_o <= 1'b1;
      va_o <= va;
      @(posedge sys_clk_i);
      req_o <= 1'b0;
      va_o <= ~va;
      #1;
      hit = done_i ? hit_i : 1'bx;
      pte = pte_i;
   endtask
   // One-cycle event with its info
   task automatic report(input logic e, input logic m, input dtm_pkg::dtm_flt_t f);
      @(posedge sys_clk_i);
      err_o <= e;
      miss_o <= m;
      info_o <= f;
      @(posedge sys_clk_i);
      err_o <= 1'b0;
      miss_o <= 1'b0;
      info_o <= ~f;
   endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   logic                   sys_clk_i, arst_n_i, reg_we_i, reg_re_i;
   logic [dtm_pkg::AW-1:0] reg_addr_i;
   logic [63:0]            reg_wdata_i, reg_rdata_o;
   logic                   lk_req_i, lk_done_o, lk_hit_o, flt_err_i, flt_miss_i;
   logic [42:0]            lk_va_i;
   dtm_pkg::dtm_pte_t      lk_pte_o, pte;
   dtm_pkg::dtm_flt_t      flt_info_i;
   logic                   flt_locked_o, ic_flush_all_o, ic_flush_ng_o, hit;
   logic [63:0]            d;
   int                     errors;
   int                     checks;
   localparam logic [42:0] VA1 = 43'h1a2b3c4d000;
   localparam logic [42:0] VA2 = 43'h5a5a5400000;
   localparam logic [63:0] PTE1 = 64'h8012345000a5a517;
   localparam logic [63:0] HLD1 = (64'h1 << 34) | (64'h123450 << 13) | (64'h5 << 9) | (64'ha << 5) | (64'h3 << 3);
   dtm_core dtm_core_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
      .lk_req_i(lk_req_i), .lk_va_i(lk_va_i), .lk_done_o(lk_done_o), .lk_hit_o(lk_hit_o),
      .lk_pte_o(lk_pte_o), .flt_err_i(flt_err_i), .flt_miss_i(flt_miss_i), .flt_info_i(flt_info_i),
      .flt_locked_o(flt_locked_o), .ic_flush_all_o(ic_flush_all_o), .ic_flush_ng_o(ic_flush_ng_o));
   dtm_lsu_model dtm_lsu_model_i (.sys_clk_i(sys_clk_i), .done_i(lk_done_o), .hit_i(lk_hit_o),
      .pte_i(lk_pte_o), .req_o(lk_req_i), .va_o(lk_va_i), .err_o(flt_err_i), .miss_o(flt_miss_i),
      .info_o(flt_info_i));
   // Free-running clock
   always #2.5 sys_clk_i = ~sys_clk_i;
   task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // Register port master: one-cycle strobes changed right after the edge
   task automatic wr(input logic [3:0] a, input logic [63:0] v);
      @(posedge sys_clk_i);
      reg_we_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge sys_clk_i);
      reg_we_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [63:0] v);
      @(posedge sys_clk_i);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_re_i <= 1'b0;
      #1 v = reg_rdata_o;
   endtask
   task automatic look(input logic [42:0] va, input logic e);
      dtm_lsu_model_i.lookup(va, hit, pte);
      cmp("lk_hit", 64'(e), 64'(hit));
   endtask
   task automatic t_small();
      cmp("locked_rst", 64'h0, 64'(flt_locked_o));
      rd(4'hf, d);
      cmp("unmapped", 64'h0, d);
      wr(dtm_pkg::OFS_PSEL, 64'h0);
      wr(dtm_pkg::OFS_PTAG, 64'(VA1));
      wr(dtm_pkg::OFS_PTE, PTE1);
      look(VA1 | 43'h123, 1'b1);
      cmp("lk_pfn", 64'h123450, 64'(pte.page_frame_number));
      look(VA1 ^ 43'h2000, 1'b0);
      // Pointer now sits at 1; the 32nd read copies entry 0 and leaves it at 1
      for (int i = 0; i < 32; i++) rd(dtm_pkg::OFS_PTE, d);
      wr(dtm_pkg::OFS_HOLD, '1);
      rd(dtm_pkg::OFS_HOLD, d);
      cmp("hold", HLD1, d);
      $display("t_small done");
   endtask
   task automatic t_inval();
      wr(dtm_pkg::OFS_PSEL, 64'h3);
      wr(dtm_pkg::OFS_PTAG, 64'(VA2));
      wr(dtm_pkg::OFS_PTE, 64'h00000abc0000ff02);
      look(VA2 | 43'h3fe000, 1'b1);
      wr(dtm_pkg::OFS_PSEL, 64'h0);
      wr(dtm_pkg::OFS_NGINV, 64'h0);
      look(VA1, 1'b1);
      look(VA2, 1'b0);
      wr(dtm_pkg::OFS_SINV, 64'(VA1));
      look(VA1, 1'b0);
      wr(dtm_pkg::OFS_PTAG, 64'(VA1));
      wr(dtm_pkg::OFS_PTE, PTE1);
      look(VA1, 1'b1);
      fork
         wr(dtm_pkg::OFS_ZAP, 64'h0);
         look(VA1, 1'b0);
      join
      look(VA1, 1'b0);
      rd(dtm_pkg::OFS_PTE, d);
      rd(dtm_pkg::OFS_HOLD, d);
      cmp("hold_zap", HLD1, d);
      $display("t_inval done");
   endtask
   // Capture, drop a second event while locked, then unlock by address read
   task automatic flt_case(input logic e, input logic m, input dtm_pkg::dtm_flt_t f, input logic [63:0] s);
      dtm_lsu_model_i.report(e, m, f);
      #1 cmp("locked", 64'h1, 64'(flt_locked_o));
      dtm_lsu_model_i.report(1'b1, 1'b1, ~f);
      rd(dtm_pkg::OFS_SYN, d);
      cmp("syndrome", s, d);
      rd(dtm_pkg::OFS_FVA, d);
      cmp("fault_va", 64'(f.va), d);
      cmp("unlocked", 64'h0, 64'(flt_locked_o));
   endtask
   task automatic t_fault();
      flt_case(1'b1, 1'b0, {4'hd, 5'h0b, 6'h2a, 43'h7edcba98765}, 64'h540b | (64'h0b << 4));
      flt_case(1'b1, 1'b0, {4'h3, 5'h15, 6'h11, 43'h0123456789a}, 64'h2204 | (64'h15 << 4));
      flt_case(1'b0, 1'b1, {4'hf, 5'h1f, 6'h3f, 43'h3c3c3c3c3c3}, 64'h7e01 | (64'h1f << 4));
      $display("t_fault done");
   endtask
   task automatic t_icache();
      wr(dtm_pkg::OFS_ICFL, 64'h0);
      #1 cmp("ic_all", 64'h2, {ic_flush_all_o, ic_flush_ng_o});
      wr(dtm_pkg::OFS_ICNG, 64'h0);
      #1 cmp("ic_ng", 64'h1, {ic_flush_all_o, ic_flush_ng_o});
      $display("t_icache done");
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      sys_clk_i = 1'b0;
      arst_n_i = 1'b0;
      reg_we_i = 1'b0;
      reg_re_i = 1'b0;
      reg_addr_i = 4'h0;
      reg_wdata_i = 64'h0;
      errors = 0;
      checks = 0;
      repeat (6) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      t_small();
      t_inval();
      t_fault();
      t_icache();
      conclude();
   end
   // Whole run needs about 150 cycles
   initial begin
      #20000;
      errors++;
      conclude();
   end
endmodule
bind dtm_core dtm_core_props dtm_core_props_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
   .reg_addr_i(reg_addr_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
   .lk_req_i(lk_req_i), .lk_done_o(lk_done_o), .lk_hit_o(lk_hit_o), .flt_err_i(flt_err_i),
   .flt_miss_i(flt_miss_i), .flt_locked_o(flt_locked_o), .ic_flush_all_o(ic_flush_all_o),
   .ic_flush_ng_o(ic_flush_ng_o));
